//--- hdl/asr_regs.svh
// Register offsets, reset values and baud timing constants of the serial receiver.
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

`define ASR_OFF_CTRL      8'h00
`define ASR_OFF_BAUD_LOW  8'h04
`define ASR_OFF_BAUD_HIGH 8'h08
`define ASR_OFF_STATUS    8'h0C
`define ASR_OFF_DATA      8'h10
`define ASR_OFF_IRQ_STAT  8'h14
`define ASR_OFF_IRQ_MASK  8'h18

`define ASR_IRQ_RX        0
`define ASR_IRQ_OVR       1
`define ASR_IRQ_FERR      2

`define ASR_CTRL_RST      7'h00
`define ASR_BAUD_RST      8'h00
`define ASR_MASK_RST      3'h0

`define ASR_SHIFT_SLOW    6
`define ASR_SHIFT_MID     4
`define ASR_SHIFT_FAST    2

`endif

//--- hdl/asr_pkg.sv
// Types shared by the serial receiver: control word, buffered character and receive states.
package asr_pkg;

   typedef struct packed {
      logic wide_divisor_select;
      logic high_speed_baud_select;
      logic address_detect_enable;
      logic nine_bit_receive_select;
      logic continuous_receive_enable;
      logic sync_mode_select;
      logic serial_port_enable;
   } asr_ctrl_t;

   typedef struct packed {
      logic       ninth;
      logic       ferr;
      logic [7:0] data;
   } asr_char_t;

   typedef enum logic [1:0] {
      ASR_IDLE  = 2'b00,
      ASR_START = 2'b01,
      ASR_DATA  = 2'b10,
      ASR_STOP  = 2'b11
   } asr_state_t;

endpackage

//--- hdl/asr_receiver.sv
// Asynchronous serial receiver with two-character buffer and APB register slave.
//
// Decided for this implementation: the register offsets and the APB slave port.
`include "asr_regs.svh"

module asr_receiver #(
   parameter int CNT_W = 23
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rx_in,
   output logic             irq
);
   import asr_pkg::*;

   asr_ctrl_t         ctrl_reg, ctrl_next;
   logic [7:0]        baud_lo_reg, baud_lo_next;
   logic [7:0]        baud_hi_reg, baud_hi_next;
   logic [2:0]        mask_reg, mask_next;
   logic [2:0]        ist_reg, ist_next;
   logic              ovr_reg, ovr_next;
   asr_char_t         buf_reg [2];
   asr_char_t         buf_next [2];
   logic              wr_reg, wr_next;
   logic              rd_reg, rd_next;
   logic [1:0]        cnt_reg, cnt_next;
   logic [31:0]       prdata_reg, prdata_next;
   logic              rd_ne_reg, rd_ne_next;

   logic              sync1_reg, sync2_reg, sync3_reg;
   asr_state_t        state_reg, state_next;
   logic [CNT_W-1:0]  tmr_reg, tmr_next;
   logic [3:0]        bitn_reg, bitn_next;
   logic [8:0]        shift_reg, shift_next;

   logic              rx_en;
   logic [CNT_W-1:0]  period;
   logic              done;
   asr_char_t         rx_char;
   logic              accept, push, pop, ovr_set;
   logic              setup, acc_wr, acc_rd, mapped;
   asr_char_t         head;
   logic              nonempty;
   logic [31:0]       rdata;

   // Bit time in pclk cycles: (divisor + 1) times 64, 16 or 4.
   function automatic logic [CNT_W-1:0] bit_period(input asr_ctrl_t c,
                                                   input logic [7:0] lo,
                                                   input logic [7:0] hi);
      logic [16:0] n;
      logic [22:0] p;
      n = c.wide_divisor_select ? ({1'b0, hi, lo} + 17'h00001) : ({9'h000, lo} + 17'h00001);
      if (c.wide_divisor_select && c.high_speed_baud_select) begin
         p = {6'h00, n} << `ASR_SHIFT_FAST;
      end else if (c.wide_divisor_select || c.high_speed_baud_select) begin
         p = {6'h00, n} << `ASR_SHIFT_MID;
      end else begin
         p = {6'h00, n} << `ASR_SHIFT_SLOW;
      end
      return CNT_W'(p);
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      return a == `ASR_OFF_CTRL || a == `ASR_OFF_BAUD_LOW || a == `ASR_OFF_BAUD_HIGH ||
             a == `ASR_OFF_STATUS || a == `ASR_OFF_DATA || a == `ASR_OFF_IRQ_STAT ||
             a == `ASR_OFF_IRQ_MASK;
   endfunction

   // Sync mode disables the asynchronous receiver altogether.
   assign rx_en  = ctrl_reg.serial_port_enable && !ctrl_reg.sync_mode_select &&
                   ctrl_reg.continuous_receive_enable;
   assign period = bit_period(ctrl_reg, baud_lo_reg, baud_hi_reg);

   // Receive state machine; the first synchroniser stage feeds only the second.
   always_comb begin
      state_next = state_reg;
      tmr_next   = tmr_reg;
      bitn_next  = bitn_reg;
      shift_next = shift_reg;
      done       = 1'b0;
      if (tmr_reg != '0) begin
         tmr_next = tmr_reg - CNT_W'(1);
      end
      case (state_reg)
         ASR_IDLE: begin
            if (sync3_reg && !sync2_reg) begin
               state_next = ASR_START;
               tmr_next   = (period >> 1) - CNT_W'(1);
            end
         end
         ASR_START: begin
            // A start bit that is high again at mid-bit is treated as a glitch.
            if (tmr_reg == '0) begin
               state_next = sync2_reg ? ASR_IDLE : ASR_DATA;
               tmr_next   = period - CNT_W'(1);
               bitn_next  = 4'h0;
            end
         end
         ASR_DATA: begin
            if (tmr_reg == '0) begin
               shift_next = {sync2_reg, shift_reg[8:1]};
               tmr_next   = period - CNT_W'(1);
               bitn_next  = bitn_reg + 4'h1;
               if (bitn_reg == (ctrl_reg.nine_bit_receive_select ? 4'h8 : 4'h7)) begin
                  state_next = ASR_STOP;
               end
            end
         end
         ASR_STOP: begin
            if (tmr_reg == '0) begin
               done       = 1'b1;
               state_next = ASR_IDLE;
            end
         end
         default: begin
            state_next = ASR_IDLE;
         end
      endcase
      if (!rx_en) begin
         state_next = ASR_IDLE;
         done       = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         sync3_reg <= 1'b1;
         state_reg <= ASR_IDLE;
         tmr_reg   <= '0;
         bitn_reg  <= 4'h0;
         shift_reg <= 9'h000;
      end else begin
         sync1_reg <= rx_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         state_reg <= state_next;
         tmr_reg   <= tmr_next;
         bitn_reg  <= bitn_next;
         shift_reg <= shift_next;
      end
   end

   // The shift register fills from the top, so 8-bit characters sit one place higher.
   always_comb begin
      rx_char.ninth = ctrl_reg.nine_bit_receive_select ? shift_reg[8] : 1'b0;
      rx_char.data  = ctrl_reg.nine_bit_receive_select ? shift_reg[7:0] : shift_reg[8:1];
      rx_char.ferr  = !sync2_reg;
   end

   // No address compare here: software inspects each address character itself.
   assign accept  = done && !(ctrl_reg.address_detect_enable && ctrl_reg.nine_bit_receive_select &&
                              !rx_char.ninth);
   assign push    = accept && !ovr_reg && cnt_reg != 2'h2;
   assign ovr_set = accept && !ovr_reg && cnt_reg == 2'h2;

   assign head     = buf_reg[rd_reg];
   assign nonempty = cnt_reg != 2'h0;
   assign setup    = psel && !penable;
   assign acc_wr   = psel && penable && pwrite;
   assign acc_rd   = psel && penable && !pwrite;
   assign mapped   = is_mapped(paddr);
   assign pop      = acc_rd && paddr == `ASR_OFF_DATA && rd_ne_reg;

   // Read data is captured at the end of the setup cycle, so side effects only touch what was reported.
   always_comb begin
      rdata = 32'h00000000;
      case (paddr)
         `ASR_OFF_CTRL:      rdata = {25'h0000000, ctrl_reg};
         `ASR_OFF_BAUD_LOW:  rdata = {24'h000000, baud_lo_reg};
         `ASR_OFF_BAUD_HIGH: rdata = {24'h000000, baud_hi_reg};
         `ASR_OFF_STATUS: begin
            rdata[0] = nonempty && (head.ninth || (ctrl_reg.address_detect_enable &&
                                                   ctrl_reg.nine_bit_receive_select));
            rdata[1] = nonempty && head.ferr;
            rdata[2] = ovr_reg;
            rdata[3] = nonempty;
            rdata[4] = state_reg != ASR_IDLE;
         end
         `ASR_OFF_DATA:      rdata = nonempty ? {24'h000000, head.data} : 32'h00000000;
         `ASR_OFF_IRQ_STAT:  rdata = {29'h00000000, ist_reg};
         `ASR_OFF_IRQ_MASK:  rdata = {29'h00000000, mask_reg};
         default:            rdata = 32'h00000000;
      endcase
   end

   always_comb begin
      ctrl_next    = ctrl_reg;
      baud_lo_next = baud_lo_reg;
      baud_hi_next = baud_hi_reg;
      mask_next    = mask_reg;
      buf_next     = buf_reg;
      wr_next      = wr_reg;
      rd_next      = rd_reg;
      prdata_next  = setup ? rdata : prdata_reg;
      rd_ne_next   = setup ? nonempty : rd_ne_reg;
      if (acc_wr) begin
         case (paddr)
            `ASR_OFF_CTRL:      ctrl_next    = asr_ctrl_t'(pwdata[6:0]);
            `ASR_OFF_BAUD_LOW:  baud_lo_next = pwdata[7:0];
            `ASR_OFF_BAUD_HIGH: baud_hi_next = pwdata[7:0];
            `ASR_OFF_IRQ_MASK:  mask_next    = pwdata[2:0];
            default:            ctrl_next    = ctrl_reg;
         endcase
      end
      if (push) begin
         buf_next[wr_reg] = rx_char;
         wr_next          = !wr_reg;
      end
      if (pop) begin
         rd_next = !rd_reg;
      end
      cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
      ovr_next = ovr_reg;
      if (ovr_set) begin
         ovr_next = 1'b1;
      end
      if (!ctrl_reg.continuous_receive_enable) begin
         ovr_next = 1'b0;
      end
      ist_next = ist_reg;
      if (acc_rd && paddr == `ASR_OFF_IRQ_STAT) begin
         ist_next = ist_reg & ~prdata_reg[2:0];
      end
      // New events are ORed in last, so a set wins over a read clear in the same cycle.
      ist_next[`ASR_IRQ_RX]   = ist_next[`ASR_IRQ_RX] | push;
      ist_next[`ASR_IRQ_OVR]  = ist_next[`ASR_IRQ_OVR] | ovr_set;
      ist_next[`ASR_IRQ_FERR] = ist_next[`ASR_IRQ_FERR] | (push && rx_char.ferr);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg    <= asr_ctrl_t'(`ASR_CTRL_RST);
         baud_lo_reg <= `ASR_BAUD_RST;
         baud_hi_reg <= `ASR_BAUD_RST;
         mask_reg    <= `ASR_MASK_RST;
         ist_reg     <= 3'h0;
         ovr_reg     <= 1'b0;
         buf_reg[0]  <= '0;
         buf_reg[1]  <= '0;
         wr_reg      <= 1'b0;
         rd_reg      <= 1'b0;
         cnt_reg     <= 2'h0;
         prdata_reg  <= 32'h00000000;
         rd_ne_reg   <= 1'b0;
      end else begin
         ctrl_reg    <= ctrl_next;
         baud_lo_reg <= baud_lo_next;
         baud_hi_reg <= baud_hi_next;
         mask_reg    <= mask_next;
         ist_reg     <= ist_next;
         ovr_reg     <= ovr_next;
         buf_reg     <= buf_next;
         wr_reg      <= wr_next;
         rd_reg      <= rd_next;
         cnt_reg     <= cnt_next;
         prdata_reg  <= prdata_next;
         rd_ne_reg   <= rd_ne_next;
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign irq     = |(ist_reg & mask_reg);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_two_deep;
      cnt_reg <= 2'h2;
   endproperty
   a_two_deep: assert property (p_two_deep) else $error("buffer count above two");

   property p_ovr_when_full;
      (done && accept && !ovr_reg && cnt_reg == 2'h2) |=> ovr_reg || !ctrl_reg.continuous_receive_enable;
   endproperty
   a_ovr_when_full: assert property (p_ovr_when_full) else $error("overrun not flagged");

   property p_ovr_clear;
      !ctrl_reg.continuous_receive_enable |=> !ovr_reg;
   endproperty
   a_ovr_clear: assert property (p_ovr_clear) else $error("overrun survived receive disable");

   property p_no_fill_in_ovr;
      ovr_reg |=> cnt_reg <= $past(cnt_reg);
   endproperty
   a_no_fill_in_ovr: assert property (p_no_fill_in_ovr) else $error("buffer grew during overrun");

   property p_rx_flag;
      push |=> ist_reg[`ASR_IRQ_RX] ##0 (irq == mask_reg[`ASR_IRQ_RX] || irq);
   endproperty
   a_rx_flag: assert property (p_rx_flag) else $error("receive flag not set on push");

   property p_idle_when_off;
      !rx_en |=> state_reg == ASR_IDLE;
   endproperty
   a_idle_when_off: assert property (p_idle_when_off) else $error("receiving while disabled");

   property p_addr_filter;
      (push && ctrl_reg.address_detect_enable && ctrl_reg.nine_bit_receive_select) |-> shift_reg[8];
   endproperty
   a_addr_filter: assert property (p_addr_filter) else $error("data char buffered in address mode");

   property p_start_detect;
      (rx_en && state_reg == ASR_IDLE && sync3_reg && !sync2_reg) |=> state_reg == ASR_START;
   endproperty
   a_start_detect: assert property (p_start_detect) else $error("start edge missed");

   property p_ferr_capture;
      (push && !sync2_reg) |=> buf_reg[$past(wr_reg)].ferr && ist_reg[`ASR_IRQ_FERR];
   endproperty
   a_ferr_capture: assert property (p_ferr_capture) else $error("framing error not recorded");

endmodule

//--- dv/asr_tx_model.sv
// Behavioural remote transmitter that drives the serial receive line.
module asr_tx_model (
   input wire logic pclk,
   output logic     line
);
   timeunit 1ns;
   timeprecision 1ps;

   // The line idles high, as a pulled-up line would between frames.
   initial begin
      line = 1'b1;
   end

   // Sends start, nb data bits LSB first and one stop bit of the given level, per cycles a bit.
   // A low stop level is the only fault this model makes, and only on request.
   task automatic send(input logic [8:0] d, input int nb, input logic stop, input int per);
      for (int i = 0; i < nb + 2; i++) begin
         line <= (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : stop;
         repeat (per) @(posedge pclk);
      end
      line <= 1'b1;
      repeat (3 * per) @(posedge pclk);
   endtask
endmodule

//--- dv/asr_receiver_tb.sv
// Self-checking bench for the serial receiver: registers, reception, errors and address mode.
`include "asr_regs.svh"
module asr_receiver_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rx_line;
   logic        irq;
   logic [31:0] rd;
   logic        err;
   int          failures;
   int          checked;
   int          cycles;

   // Port enable, receive enable, high speed and wide divisor: a bit is (1+1)*4 = 8 cycles.
   localparam logic [31:0] RUN = 32'h0000_0065;

   asr_receiver u_dut (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .rx_in   (rx_line),
      .irq     (irq)
   );

   asr_tx_model u_tx (
      .pclk (pclk),
      .line (rx_line)
   );

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; the idle edge at entry keeps two transfers from colliding in one step.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic irq_chk(input logic exp);
      @(negedge pclk);
      chk({31'h0, irq}, {31'h0, exp});
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      failures = 0;
      checked = 0;
      cycles = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;

      rchk(`ASR_OFF_CTRL, 32'h0);
      rchk(`ASR_OFF_IRQ_MASK, 32'h0);
      rchk(`ASR_OFF_STATUS, 32'h0);
      apb(1'b0, 8'h1C, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("test reset done");

      apb(1'b1, `ASR_OFF_BAUD_LOW, 32'h1);
      apb(1'b1, `ASR_OFF_CTRL, RUN);
      rchk(`ASR_OFF_CTRL, RUN);
      u_tx.send(9'h0A5, 8, 1'b1, 8);
      rchk(`ASR_OFF_STATUS, 32'h08);
      irq_chk(1'b0);
      apb(1'b1, `ASR_OFF_IRQ_MASK, 32'h1);
      irq_chk(1'b1);
      rchk(`ASR_OFF_IRQ_STAT, 32'h1);
      irq_chk(1'b0);
      rchk(`ASR_OFF_DATA, 32'hA5);
      rchk(`ASR_OFF_STATUS, 32'h0);
      $display("test single character done");

      for (int i = 1; i <= 4; i++)
         u_tx.send(9'(i * 17), 8, 1'b1, 8);
      rchk(`ASR_OFF_STATUS, 32'h0C);
      rchk(`ASR_OFF_IRQ_STAT, 32'h3);
      rchk(`ASR_OFF_DATA, 32'h11);
      rchk(`ASR_OFF_DATA, 32'h22);
      u_tx.send(9'h055, 8, 1'b1, 8);
      rchk(`ASR_OFF_DATA, 32'h0);
      apb(1'b1, `ASR_OFF_CTRL, 32'h61);
      rchk(`ASR_OFF_STATUS, 32'h0);
      apb(1'b1, `ASR_OFF_CTRL, RUN);
      apb(1'b0, `ASR_OFF_IRQ_STAT, 32'h0);
      $display("test overrun done");

      u_tx.send(9'h05A, 8, 1'b0, 8);
      rchk(`ASR_OFF_STATUS, 32'h0A);
      rchk(`ASR_OFF_IRQ_STAT, 32'h5);
      rchk(`ASR_OFF_DATA, 32'h5A);
      $display("test framing done");

      apb(1'b1, `ASR_OFF_CTRL, 32'h6D);
      u_tx.send(9'h13C, 9, 1'b1, 8);
      u_tx.send(9'h0C3, 9, 1'b1, 8);
      rchk(`ASR_OFF_STATUS, 32'h09);
      rchk(`ASR_OFF_DATA, 32'h3C);
      rchk(`ASR_OFF_STATUS, 32'h08);
      rchk(`ASR_OFF_DATA, 32'hC3);
      $display("test nine bit done");

      apb(1'b1, `ASR_OFF_CTRL, 32'h7D);
      u_tx.send(9'h055, 9, 1'b1, 8);
      u_tx.send(9'h142, 9, 1'b1, 8);
      rchk(`ASR_OFF_STATUS, 32'h09);
      rchk(`ASR_OFF_DATA, 32'h42);
      rchk(`ASR_OFF_DATA, 32'h0);
      apb(1'b1, `ASR_OFF_CTRL, 32'h6D);
      u_tx.send(9'h066, 9, 1'b1, 8);
      rchk(`ASR_OFF_STATUS, 32'h08);
      rchk(`ASR_OFF_DATA, 32'h66);
      $display("test address mode done");

      apb(1'b1, `ASR_OFF_CTRL, 32'h61);
      u_tx.send(9'h077, 8, 1'b1, 8);
      rchk(`ASR_OFF_STATUS, 32'h0);
      $display("test receive disabled done");

      // Exactly one of high speed or wide divisor, divisor zero: a bit is 16 cycles.
      apb(1'b1, `ASR_OFF_BAUD_LOW, 32'h0);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, `ASR_OFF_CTRL, (i == 0) ? 32'h25 : 32'h45);
         u_tx.send(9'(8'h3C + i), 8, 1'b1, 16);
         rchk(`ASR_OFF_DATA, 32'h3C + i);
      end
      apb(1'b1, `ASR_OFF_BAUD_HIGH, 32'hFF);
      rchk(`ASR_OFF_BAUD_HIGH, 32'hFF);
      // The high divisor byte only counts in wide mode, so a bit stays 16 cycles here.
      apb(1'b1, `ASR_OFF_CTRL, 32'h25);
      u_tx.send(9'h0E1, 8, 1'b1, 16);
      rchk(`ASR_OFF_DATA, 32'hE1);
      // With neither select bit and divisor zero, a bit is 64 cycles.
      apb(1'b1, `ASR_OFF_CTRL, 32'h05);
      u_tx.send(9'h096, 8, 1'b1, 64);
      rchk(`ASR_OFF_DATA, 32'h96);
      $display("test divisor done");

      // Sync mode set keeps the asynchronous receiver idle, so nothing is buffered and it never looks busy.
      apb(1'b1, `ASR_OFF_CTRL, 32'h27);
      u_tx.send(9'h0B4, 8, 1'b1, 16);
      rchk(`ASR_OFF_STATUS, 32'h0);
      rchk(`ASR_OFF_DATA, 32'h0);
      $display("test sync mode done");
      conclude();
   end
endmodule
